// ### verilog/ipe_top.sv
`timescale 1ns/10ps
`default_nettype none
module ipe_top (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  src_group0,
    input  wire logic [7:0]  src_group2,
    input  wire logic [7:0]  porta_pin,
    input  wire logic [7:0]  portd_pin,
    output logic             irq_valid,
    output logic [4:0]       irq_vector,
    input  wire logic        irq_ack
);
    logic [7:0]  request0_reg;
    logic [7:0]  request1_reg;
    logic [7:0]  request2_reg;
    logic [7:0]  group0_enable_high_reg;
    logic [7:0]  group0_enable_low_reg;
    logic [7:0]  group1_enable_high_reg;
    logic [7:0]  group1_enable_low_reg;
    logic [7:0]  group2_enable_high_reg;
    logic [7:0]  group2_enable_low_reg;
    logic [7:0]  edge_select_reg;
    logic [7:0]  port_select_reg;
    logic        global_interrupt_enable_reg;
    logic [7:0]  porta_meta_reg;
    logic [7:0]  porta_sync_reg;
    logic [7:0]  portd_meta_reg;
    logic [7:0]  portd_sync_reg;
    logic [7:0]  pin_prev_reg;
    logic [31:0] prdata_reg;
    logic        irq_valid_reg;
    logic [4:0]  irq_vector_reg;

    logic [11:0] word;
    logic        aligned;
    logic        mapped;
    logic        wr_en;
    logic        access;
    logic [7:0]  read_byte;
    logic [7:0]  pin_sel;
    logic [7:0]  pin_event;
    logic [23:0] ack_mask;
    logic [23:0] pending;
    logic [23:0] enable_high;
    logic [23:0] enable_low;
    logic [47:0] level;
    logic        found;
    logic [4:0]  vector;
    logic [7:0]  request0_next;
    logic [7:0]  request1_next;
    logic [7:0]  request2_next;

    assign word    = paddr[13:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign access  = psel & penable;
    assign wr_en   = access & pwrite & mapped;
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_reg;

    // address decode and read mux; reserved control bits read zero
    always_comb begin
        mapped    = aligned;
        read_byte = ipe_pkg::ipe_reset_byte;
        unique case (word)
            ipe_pkg::ipe_idx_request0:     read_byte = request0_reg;
            ipe_pkg::ipe_idx_enable0_high: read_byte = group0_enable_high_reg;
            ipe_pkg::ipe_idx_enable0_low:  read_byte = group0_enable_low_reg;
            ipe_pkg::ipe_idx_request1:     read_byte = request1_reg;
            ipe_pkg::ipe_idx_enable1_high: read_byte = group1_enable_high_reg;
            ipe_pkg::ipe_idx_enable1_low:  read_byte = group1_enable_low_reg;
            ipe_pkg::ipe_idx_request2:     read_byte = request2_reg;
            ipe_pkg::ipe_idx_enable2_high: read_byte = group2_enable_high_reg;
            ipe_pkg::ipe_idx_enable2_low:  read_byte = group2_enable_low_reg;
            ipe_pkg::ipe_idx_edge_select:  read_byte = edge_select_reg;
            ipe_pkg::ipe_idx_port_select:  read_byte = port_select_reg;
            ipe_pkg::ipe_idx_control:
                read_byte = {global_interrupt_enable_reg, 7'h00};
            default:                       mapped    = 1'b0;
        endcase
    end

    // read data is caught in the setup cycle so it comes from a flop
    always_ff @(posedge clock) begin
        if (!nrst) begin
            prdata_reg <= ipe_pkg::ipe_reset_word;
        end else if (psel && !penable) begin
            prdata_reg <= (mapped && !pwrite) ? {24'h000000, read_byte}
                                              : ipe_pkg::ipe_reset_word;
        end
    end

    // group0 high enable, bit 7 timer2 down to bit 0 converter
    always_ff @(posedge clock) begin
        if (!nrst) begin
            group0_enable_high_reg <= ipe_pkg::ipe_reset_byte;
        end else if (wr_en && word == ipe_pkg::ipe_idx_enable0_high) begin
            group0_enable_high_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            group0_enable_low_reg <= ipe_pkg::ipe_reset_byte;
        end else if (wr_en && word == ipe_pkg::ipe_idx_enable0_low) begin
            group0_enable_low_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            group1_enable_high_reg <= ipe_pkg::ipe_reset_byte;
            group1_enable_low_reg  <= ipe_pkg::ipe_reset_byte;
        end else begin
            if (wr_en && word == ipe_pkg::ipe_idx_enable1_high) begin
                group1_enable_high_reg <= pwdata[7:0];
            end
            if (wr_en && word == ipe_pkg::ipe_idx_enable1_low) begin
                group1_enable_low_reg <= pwdata[7:0];
            end
        end
    end

    // group2 high enable, timer3 down to portc pin 0
    always_ff @(posedge clock) begin
        if (!nrst) begin
            group2_enable_high_reg <= ipe_pkg::ipe_reset_byte;
        end else if (wr_en && word == ipe_pkg::ipe_idx_enable2_high) begin
            group2_enable_high_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            group2_enable_low_reg <= ipe_pkg::ipe_reset_byte;
        end else if (wr_en && word == ipe_pkg::ipe_idx_enable2_low) begin
            group2_enable_low_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            edge_select_reg <= ipe_pkg::ipe_reset_byte;
            port_select_reg <= ipe_pkg::ipe_reset_byte;
        end else begin
            if (wr_en && word == ipe_pkg::ipe_idx_edge_select) begin
                edge_select_reg <= pwdata[7:0];
            end
            if (wr_en && word == ipe_pkg::ipe_idx_port_select) begin
                port_select_reg <= pwdata[7:0];
            end
        end
    end

    // pins are asynchronous: two flops before anything looks at them
    always_ff @(posedge clock) begin
        if (!nrst) begin
            porta_meta_reg <= ipe_pkg::ipe_reset_byte;
            porta_sync_reg <= ipe_pkg::ipe_reset_byte;
            portd_meta_reg <= ipe_pkg::ipe_reset_byte;
            portd_sync_reg <= ipe_pkg::ipe_reset_byte;
            pin_prev_reg   <= ipe_pkg::ipe_reset_byte;
        end else begin
            porta_meta_reg <= porta_pin;
            porta_sync_reg <= porta_meta_reg;
            portd_meta_reg <= portd_pin;
            portd_sync_reg <= portd_meta_reg;
            pin_prev_reg   <= pin_sel;
        end
    end

    // each pin position takes port a or port d as selected
    assign pin_sel = (port_select_reg & portd_sync_reg) | (~port_select_reg & porta_sync_reg);
    // changing the port select can look like an edge; software should clear afterwards
    assign pin_event = (edge_select_reg & pin_sel & ~pin_prev_reg)
                     | (~edge_select_reg & ~pin_sel & pin_prev_reg);

    // an acknowledge retires exactly the request that was presented
    assign ack_mask = (irq_ack && irq_valid_reg) ? (24'h000001 << irq_vector_reg) : 24'h000000;

    // sources set their bit; set wins over a clear in the same cycle
    always_comb begin
        request0_next = request0_reg & ~ack_mask[7:0];
        request1_next = request1_reg & ~ack_mask[15:8];
        request2_next = request2_reg & ~ack_mask[23:16];
        if (wr_en && word == ipe_pkg::ipe_idx_request0) begin
            request0_next = pwdata[7:0];
        end
        if (wr_en && word == ipe_pkg::ipe_idx_request1) begin
            request1_next = pwdata[7:0];
        end
        if (wr_en && word == ipe_pkg::ipe_idx_request2) begin
            request2_next = pwdata[7:0];
        end
        request0_next = request0_next | src_group0;
        request1_next = request1_next | pin_event;
        request2_next = request2_next | src_group2;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            request0_reg <= ipe_pkg::ipe_reset_byte;
            request1_reg <= ipe_pkg::ipe_reset_byte;
            request2_reg <= ipe_pkg::ipe_reset_byte;
        end else begin
            request0_reg <= request0_next;
            request1_reg <= request1_next;
            request2_reg <= request2_next;
        end
    end

    // global enable: an acknowledge clears it, a software write that lands
    // in the same cycle wins so an enable request is never lost
    always_ff @(posedge clock) begin
        if (!nrst) begin
            global_interrupt_enable_reg <= 1'b0;
        end else if (wr_en && word == ipe_pkg::ipe_idx_control) begin
            global_interrupt_enable_reg <= pwdata[ipe_pkg::ipe_gie_bit];
        end else if (irq_ack && irq_valid_reg) begin
            global_interrupt_enable_reg <= 1'b0;
        end
    end

    assign pending     = {request2_reg, request1_reg, request0_reg};
    assign enable_high = {group2_enable_high_reg, group1_enable_high_reg, group0_enable_high_reg};
    assign enable_low  = {group2_enable_low_reg, group1_enable_low_reg, group0_enable_low_reg};

    // pair high and low bits into a level code
    for (genvar i = 0; i < ipe_pkg::ipe_src_count; i++) begin : g_level
        assign level[2*i +: 2] = {enable_high[i], enable_low[i]};
    end

    ipe_select u_select (
        .pending (pending),
        .level   (level),
        .found   (found),
        .vector  (vector)
    );

    // present to the core only while globally enabled
    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_valid_reg  <= 1'b0;
            irq_vector_reg <= 5'h00;
        end else begin
            irq_valid_reg  <= global_interrupt_enable_reg & found & ~(irq_ack & irq_valid_reg);
            irq_vector_reg <= vector;
        end
    end

    assign irq_valid  = irq_valid_reg;
    assign irq_vector = irq_vector_reg;
endmodule // ipe_top
`default_nettype wire

// ### verilog/ipe_pkg.sv
`default_nettype none
package ipe_pkg;
    // register indexes; the byte address on the bus is four times the index
    localparam logic [11:0] ipe_idx_request0     = 12'hfc0;
    localparam logic [11:0] ipe_idx_enable0_high = 12'hfc1;
    localparam logic [11:0] ipe_idx_enable0_low  = 12'hfc2;
    localparam logic [11:0] ipe_idx_request1     = 12'hfc3;
    localparam logic [11:0] ipe_idx_enable1_high = 12'hfc4;
    localparam logic [11:0] ipe_idx_enable1_low  = 12'hfc5;
    localparam logic [11:0] ipe_idx_request2     = 12'hfc6;
    localparam logic [11:0] ipe_idx_enable2_high = 12'hfc7;
    localparam logic [11:0] ipe_idx_enable2_low  = 12'hfc8;
    localparam logic [11:0] ipe_idx_edge_select  = 12'hfcd;
    localparam logic [11:0] ipe_idx_port_select  = 12'hfce;
    localparam logic [11:0] ipe_idx_control      = 12'hfcf;

    localparam logic [7:0]  ipe_reset_byte       = 8'h00;
    localparam logic [31:0] ipe_reset_word       = 32'h0000_0000;
    localparam int          ipe_gie_bit          = 7;
    localparam int          ipe_src_count        = 24;
    localparam int          ipe_vector_width     = 5;
    localparam int          ipe_addr_width       = 14;

    typedef enum logic [1:0] {
        ipe_level_off     = 2'b00,
        ipe_level_low     = 2'b01,
        ipe_level_nominal = 2'b10,
        ipe_level_high    = 2'b11
    } ipe_level_type;
endpackage
`default_nettype wire

// ### verilog/ipe_select.sv
`timescale 1ns/10ps
`default_nettype none
module ipe_select (
    input  wire logic [23:0] pending,
    input  wire logic [47:0] level,
    output logic             found,
    output logic [4:0]       vector
);
    logic [1:0] best;

    // level then order: scanning downward with >= lets the lowest index win a tie
    always_comb begin
        best   = ipe_pkg::ipe_level_off;
        found  = 1'b0;
        vector = 5'h00;
        for (int i = ipe_pkg::ipe_src_count - 1; i >= 0; i--) begin
            if (pending[i] && (level[2*i +: 2] != ipe_pkg::ipe_level_off)
                && (level[2*i +: 2] >= best)) begin
                best   = level[2*i +: 2];
                found  = 1'b1;
                vector = 5'(i);
            end
        end
    end
endmodule // ipe_select
`default_nettype wire

// ### bench/ipe_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module ipe_core_model (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic slow,
    input  wire logic irq_valid,
    output logic      irq_ack
);
    logic [2:0] wait_reg;
    // a slow core leaves the request standing, so hold-until-ack gets exercised
    always_ff @(posedge clock) begin
        if (!nrst || !irq_valid || irq_ack) begin
            wait_reg <= 3'h0;
            irq_ack  <= 1'b0;
        end else if (wait_reg >= (slow ? 3'h5 : 3'h0)) begin
            irq_ack <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 3'h1;
        end
    end
endmodule // ipe_core_model
`default_nettype wire

// ### bench/ipe_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ipe_top_asserts (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq_valid,
    input wire logic [4:0]  irq_vector,
    input wire logic        irq_ack
);
    logic mapped;
    logic ctl_wr;
    assign mapped = paddr[1:0] == 2'h0 && (paddr[13:2] inside
        {[ipe_pkg::ipe_idx_request0:ipe_pkg::ipe_idx_enable2_low],
         [ipe_pkg::ipe_idx_edge_select:ipe_pkg::ipe_idx_control]});
    assign ctl_wr = psel && penable && pwrite && paddr[13:2] == ipe_pkg::ipe_idx_control;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    a_ready_always: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
        else $error("error on mapped access");
    a_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
    a_rdata_stands: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    a_ack_drop: assert property (
        irq_valid && irq_ack |=> !irq_valid) else $error("request kept after ack");
    // a control write reaches irq_valid two edges later, so the cycle after it is skipped too
    a_valid_hold: assert property (
        irq_valid && !irq_ack && !ctl_wr && !$past(ctl_wr) |=> irq_valid)
        else $error("request dropped unserved");
    a_vector_range: assert property (
        irq_valid |-> irq_vector < 5'h18) else $error("vector out of range");
    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst |=> !irq_valid && prdata == 32'h0) else $error("outputs active in reset");
    c_ack: cover property (irq_valid && irq_ack);
    c_err: cover property (psel && penable && pslverr);
    c_wait: cover property (irq_valid && !irq_ack [*3]);
endmodule // ipe_top_asserts
bind ipe_top ipe_top_asserts ipe_top_asserts_i (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_valid(irq_valid), .irq_vector(irq_vector), .irq_ack(irq_ack));
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clock, nrst, psel, penable, pwrite, pready, pslverr, irq_valid, irq_ack, slow;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  src_group0, src_group2, porta_pin, portd_pin;
    logic [4:0]  irq_vector;
    logic        er;
    int          bad_count, total_checks;
    ipe_top ipe_top_i (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_group0(src_group0), .src_group2(src_group2),
        .porta_pin(porta_pin), .portd_pin(portd_pin), .irq_valid(irq_valid),
        .irq_vector(irq_vector), .irq_ack(irq_ack));
    ipe_core_model ipe_core_model_i (.clock(clock), .nrst(nrst), .slow(slow),
        .irq_valid(irq_valid), .irq_ack(irq_ack));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task summarize;
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function logic [13:0] ad(input logic [11:0] i);
        return {i, 2'h0};
    endfunction
    task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr_chk(input logic [11:0] i, input logic [31:0] d);
        apb(1'b1, ad(i), d);
        apb(1'b0, ad(i), 32'h0);
        chk(rd, {24'h0, d[7:0]});
    endtask
    task wait_ack(input logic [4:0] v);
        repeat (40) begin
            @(negedge clock);
            if (irq_ack === 1'b1) break;
        end
        chk({irq_ack, 26'h0, irq_vector}, {1'b1, 26'h0, v});
    endtask
    task t_reset;
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, i < 9 ? ad(ipe_pkg::ipe_idx_request0 + 12'(i))
                : ad(ipe_pkg::ipe_idx_edge_select + 12'(i - 9)), 32'h0);
            chk({31'h0, er}, 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 14'h3f24, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        // unaligned write must leave the register alone
        apb(1'b1, 14'h3f05, 32'hff);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, ad(ipe_pkg::ipe_idx_enable0_high), 32'h0);
        chk(rd, 32'h0);
    endtask
    task t_priority;
        logic [4:0] order [4] = '{5'h14, 5'h00, 5'h01, 5'h05};
        wr_chk(ipe_pkg::ipe_idx_enable0_high, 32'hffff_ff01);
        wr_chk(ipe_pkg::ipe_idx_enable0_low, 32'h0000_0122);
        wr_chk(ipe_pkg::ipe_idx_enable2_high, 32'h10);
        wr_chk(ipe_pkg::ipe_idx_enable2_low, 32'h10);
        @(posedge clock);
        src_group0 <= 8'h27; src_group2 <= 8'h10;
        @(posedge clock);
        src_group0 <= 8'h00; src_group2 <= 8'h00;
        repeat (3) @(negedge clock);
        chk({31'h0, irq_valid}, 32'h0);
        apb(1'b0, ad(ipe_pkg::ipe_idx_request0), 32'h0);
        chk(rd, 32'h27);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ad(ipe_pkg::ipe_idx_control), 32'h80);
            wait_ack(order[i]);
        end
        apb(1'b1, ad(ipe_pkg::ipe_idx_control), 32'h80);
        repeat (4) @(negedge clock);
        chk({31'h0, irq_valid}, 32'h0);
        apb(1'b0, ad(ipe_pkg::ipe_idx_request0), 32'h0);
        chk(rd, 32'h04);
        apb(1'b1, ad(ipe_pkg::ipe_idx_control), 32'h0);
    endtask
    task t_pins;
        slow <= 1'b1;
        wr_chk(ipe_pkg::ipe_idx_port_select, 32'h08);
        wr_chk(ipe_pkg::ipe_idx_edge_select, 32'h08);
        wr_chk(ipe_pkg::ipe_idx_enable1_high, 32'h08);
        wr_chk(ipe_pkg::ipe_idx_enable1_low, 32'h08);
        @(posedge clock);
        porta_pin <= 8'h08;
        repeat (8) @(negedge clock);
        apb(1'b0, ad(ipe_pkg::ipe_idx_request1), 32'h0);
        chk(rd, 32'h0);
        @(posedge clock);
        portd_pin <= 8'h08;
        repeat (8) @(negedge clock);
        apb(1'b0, ad(ipe_pkg::ipe_idx_request1), 32'h0);
        chk({irq_valid, rd[30:0]}, 32'h08);
        apb(1'b1, ad(ipe_pkg::ipe_idx_control), 32'h80);
        wait_ack(5'h0b);
        apb(1'b0, ad(ipe_pkg::ipe_idx_request1), 32'h0);
        chk(rd, 32'h0);
        // falling-edge mode: the pin going low must raise the same request again
        wr_chk(ipe_pkg::ipe_idx_edge_select, 32'h00);
        @(posedge clock);
        portd_pin <= 8'h00;
        repeat (8) @(negedge clock);
        apb(1'b0, ad(ipe_pkg::ipe_idx_request1), 32'h0);
        chk(rd, 32'h08);
    endtask
    initial begin
        #500000;
        bad_count++;
        summarize();
    end
    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 14'h0;
        pwdata = 32'h0; src_group0 = 8'h0; src_group2 = 8'h0; porta_pin = 8'h0;
        portd_pin = 8'h0; slow = 1'b0; bad_count = 0; total_checks = 0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_priority();
        t_pins();
        summarize();
    end
endmodule // tb
`default_nettype wire
